// ===== adcsq_pkg.sv
// shared constants, carrier structs and state layout of the sample sequencer
package adcsq_pkg;
    localparam int NSEQ = 4;
    localparam int NSTEP = 8;
    localparam int RES_W = 10;
    localparam int WORD_W = 32;
    localparam int EXT_TRIG = 14;
    // converter-rate divider, rounded to the nearest whole ratio
    localparam int MCLK_KHZ = 250000;
    localparam int ADC_KHZ = 16667;
    localparam int ADC_DIV = (MCLK_KHZ + ADC_KHZ / 2) / ADC_KHZ;
    localparam logic [3:0] DIV_LAST = 4'(ADC_DIV - 1);
    // per-sequencer depth, index 0 is sequencer zero
    localparam logic [3:0][3:0] SEQ_DEPTH = {4'h1, 4'h4, 4'h4, 4'h8};
    // step control nibble fields
    localparam int CTL_DIFF = 0;
    localparam int CTL_END = 1;
    localparam int CTL_IE = 2;
    localparam int CTL_TEMP = 3;
    // trigger select codes; 1..14 pick external trigger code-1
    localparam logic [3:0] TRIG_PROC = 4'h0;
    localparam logic [3:0] TRIG_ALWAYS = 4'hF;
    localparam logic [7:0] PRIO_RST = 8'hE4;
    localparam logic [2:0] AVG_RST = 3'h0;
    localparam logic [2:0] AVG_MAX = 3'h6;
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} adcsq_state_t;
    typedef struct packed {
        logic [2:0] head;
        logic [2:0] tail;
        logic full;
        logic empty;
    } adcsq_qstat_t;
    typedef struct packed {
        logic [3:0] pos;
        logic [3:0] neg;
        logic diff;
        logic temp;
    } adcsq_conv_t;
    typedef struct packed {
        adcsq_state_t st;
        logic [1:0] cur;
        logic [2:0] step;
        logic [3:0] pend;
        logic [3:0] tick_cnt;
        logic tick;
        logic [15:0] acc;
        logic [6:0] acnt;
        logic [3:0][1:0] prio;
        logic [2:0] avg;
        logic [3:0][7:0][9:0] mem;
        logic [3:0][2:0] head;
        logic [3:0][2:0] tail;
        logic [3:0][3:0] cnt;
        adcsq_qstat_t [3:0] qstat;
        logic [3:0] raw;
        logic [3:0] gated;
        logic [3:0] ovf;
        logic [3:0] unf;
        logic [13:0] sy1;
        logic [13:0] sy2;
        logic [13:0] sy3;
        logic [13:0] filt;
        logic conv_start;
        adcsq_conv_t conv;
        logic [31:0] pop_data;
        logic pop_valid;
    } adcsq_regs_t;
endpackage : adcsq_pkg

// ===== adcsq_top.sv
// four-sequencer converter control: triggers, arbitration, averaging, queues, irq
`timescale 1ns/1ps
module adcsq_top
    import adcsq_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [3:0] run_bits,
    input wire logic [3:0][3:0] trigger_select,
    input wire logic [3:0] software_trigger_bit,
    input wire logic [13:0] ext_trig,
    input wire logic prio_wr,
    input wire logic [7:0] prio_wdata,
    input wire logic avg_wr,
    input wire logic [2:0] avg_wdata,
    input wire logic [3:0][7:0][3:0] step_input_select,
    input wire logic [3:0][7:0][3:0] step_control,
    input wire logic [3:0] irq_gate,
    input wire logic [3:0] irq_clear,
    input wire logic [3:0] ovf_clear,
    input wire logic [3:0] unf_clear,
    input wire logic [3:0] pop_req,
    input wire logic conv_done,
    input wire logic [9:0] conv_code,
    output logic conv_start,
    output adcsq_conv_t conv_sel,
    output logic [31:0] pop_data,
    output logic pop_valid,
    output adcsq_qstat_t [3:0] result_queue_status,
    output logic [3:0] queue_overflow_status,
    output logic [3:0] queue_underflow_status,
    output logic [3:0] raw_irq_status,
    output logic [3:0] gated_irq_status,
    output logic [3:0] irq_line,
    output logic [7:0] sequencer_priority,
    output logic [2:0] averaging_control
);
    adcsq_regs_t s_r;
    adcsq_regs_t s_nxt;
    logic [13:0] ext_edge;
    logic [3:0] set_pend;
    logic [3:0] clr_pend;
    logic [3:0] pop_ok;
    logic [3:0] push_ok;
    logic [3:0] irq_set;
    logic [3:0] ovf_set;
    logic [3:0] unf_set;
    logic last_avg;
    logic do_push;
    logic found;
    logic [1:0] win;
    logic [1:0] bestp;
    logic [3:0] ctl;
    logic [3:0] sel;
    logic [15:0] sum;
    logic [9:0] res;

    // ring pointer advance inside a queue of the given depth
    function automatic logic [2:0] ptr_inc(input logic [2:0] p, input logic [3:0] d);
        ptr_inc = ({1'b0, p} == d - 4'h1) ? 3'h0 : p + 3'h1;
    endfunction : ptr_inc

    // whole next-state of the block
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        s_nxt.conv_start = 1'b0;
        s_nxt.pop_valid = 1'b0;
        set_pend = 4'h0;
        clr_pend = 4'h0;
        pop_ok = 4'h0;
        push_ok = 4'h0;
        irq_set = 4'h0;
        ovf_set = 4'h0;
        unf_set = 4'h0;
        do_push = 1'b0;
        found = 1'b0;
        win = 2'h0;
        bestp = 2'h3;
        ctl = step_control[s_r.cur][s_r.step];
        sel = step_input_select[s_r.cur][s_r.step];
        sum = s_r.acc + {6'h0, conv_code};
        res = 10'(sum >> s_r.avg);
        last_avg = (s_r.acnt == 7'((7'h1 << s_r.avg) - 7'h1));
        // divider gives one step slot per ADC clock period
        if (s_r.tick_cnt == DIV_LAST) begin
            s_nxt.tick_cnt = 4'h0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 4'h1;
        end
        // pin triggers: three stages, accepted when the last two agree
        s_nxt.sy1 = ext_trig;
        s_nxt.sy2 = s_r.sy1;
        s_nxt.sy3 = s_r.sy2;
        for (int b = 0; b < EXT_TRIG; b++) begin
            if (s_r.sy2[b] == s_r.sy3[b]) begin
                s_nxt.filt[b] = s_r.sy3[b];
            end
        end
        ext_edge = s_nxt.filt & ~s_r.filt;
        // trigger selection per sequencer
        for (int i = 0; i < NSEQ; i++) begin
            if (software_trigger_bit[i]) begin
                set_pend[i] = 1'b1;
            end
            if (trigger_select[i] == TRIG_ALWAYS) begin
                set_pend[i] = 1'b1;
            end else if (trigger_select[i] != TRIG_PROC) begin
                if (ext_edge[trigger_select[i] - 4'h1]) begin
                    set_pend[i] = 1'b1;
                end
            end
        end
        // configuration registers; their reset values live in the package
        if (prio_wr) begin
            s_nxt.prio = prio_wdata;
        end
        if (avg_wr) begin
            s_nxt.avg = (avg_wdata > AVG_MAX) ? AVG_MAX : avg_wdata;
        end
        // pops: oldest entry out, empty read flags underflow
        for (int i = 0; i < NSEQ; i++) begin
            if (pop_req[i]) begin
                if (s_r.cnt[i] == 4'h0) begin
                    unf_set[i] = 1'b1;
                end else begin
                    pop_ok[i] = 1'b1;
                    s_nxt.head[i] = ptr_inc(s_r.head[i], SEQ_DEPTH[i]);
                end
            end
        end
        // only one pop per cycle is reported; the lowest index wins
        for (int i = NSEQ - 1; i >= 0; i--) begin
            if (pop_ok[i]) begin
                s_nxt.pop_valid = 1'b1;
                s_nxt.pop_data = {22'h0, s_r.mem[i][s_r.head[i]]};
            end
        end
        // arbitration among enabled pending sequencers
        for (int i = 0; i < NSEQ; i++) begin
            if (s_r.pend[i] && run_bits[i] && (!found || s_r.prio[i] < bestp)) begin
                found = 1'b1;
                bestp = s_r.prio[i];
                win = 2'(i);
            end
        end
        case (s_r.st)
            ST_IDLE: begin
                if (s_r.tick && found) begin
                    s_nxt.cur = win;
                    s_nxt.step = 3'h0;
                    s_nxt.acc = 16'h0;
                    s_nxt.acnt = 7'h0;
                    s_nxt.st = ST_START;
                end
            end
            ST_START: begin
                if (s_r.tick) begin
                    s_nxt.conv_start = 1'b1;
                    s_nxt.conv.diff = ctl[CTL_DIFF];
                    s_nxt.conv.temp = ctl[CTL_TEMP];
                    // a step names pair n: even input positive, odd negative
                    s_nxt.conv.pos = ctl[CTL_DIFF] ? {sel[2:0], 1'b0} : sel;
                    s_nxt.conv.neg = ctl[CTL_DIFF] ? {sel[2:0], 1'b1} : 4'h0;
                    s_nxt.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (conv_done && !last_avg) begin
                    s_nxt.acc = sum;
                    s_nxt.acnt = s_r.acnt + 7'h1;
                    s_nxt.st = ST_START;
                end else if (conv_done) begin
                    do_push = 1'b1;
                    s_nxt.acc = 16'h0;
                    s_nxt.acnt = 7'h0;
                    if (ctl[CTL_IE]) begin
                        irq_set[s_r.cur] = 1'b1;
                    end
                    // also stops at the sequencer's last slot or when disabled
                    if (ctl[CTL_END] || ({1'b0, s_r.step} == SEQ_DEPTH[s_r.cur] - 4'h1)
                            || !run_bits[s_r.cur]) begin
                        clr_pend[s_r.cur] = 1'b1;
                        s_nxt.st = ST_IDLE;
                    end else begin
                        s_nxt.step = s_r.step + 3'h1;
                        s_nxt.st = ST_START;
                    end
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        // push the finished result; a full queue drops it
        if (do_push) begin
            if (s_r.cnt[s_r.cur] == SEQ_DEPTH[s_r.cur]) begin
                ovf_set[s_r.cur] = 1'b1;
            end else begin
                push_ok[s_r.cur] = 1'b1;
                s_nxt.mem[s_r.cur][s_r.tail[s_r.cur]] = res;
                s_nxt.tail[s_r.cur] = ptr_inc(s_r.tail[s_r.cur], SEQ_DEPTH[s_r.cur]);
            end
        end
        // counts and visible queue status
        for (int i = 0; i < NSEQ; i++) begin
            if (push_ok[i] && !pop_ok[i]) begin
                s_nxt.cnt[i] = s_r.cnt[i] + 4'h1;
            end else if (pop_ok[i] && !push_ok[i]) begin
                s_nxt.cnt[i] = s_r.cnt[i] - 4'h1;
            end
            s_nxt.qstat[i].head = s_nxt.head[i];
            s_nxt.qstat[i].tail = s_nxt.tail[i];
            s_nxt.qstat[i].full = (s_nxt.cnt[i] == SEQ_DEPTH[i]);
            s_nxt.qstat[i].empty = (s_nxt.cnt[i] == 4'h0);
        end
        // sticky flags: a set in the clearing cycle survives
        s_nxt.ovf = (s_r.ovf & ~ovf_clear) | ovf_set;
        s_nxt.unf = (s_r.unf & ~unf_clear) | unf_set;
        s_nxt.raw = (s_r.raw & ~irq_clear) | irq_set;
        s_nxt.gated = s_nxt.raw & irq_gate;
        // disabled sequencers drop pending triggers so they start clean
        s_nxt.pend = ((s_r.pend & ~clr_pend) | set_pend) & run_bits;
    end

    // state register; clock enable freezes everything
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.prio <= PRIO_RST;
            s_r.avg <= AVG_RST;
            for (int i = 0; i < NSEQ; i++) begin
                s_r.qstat[i].empty <= 1'b1;
            end
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign conv_start = s_r.conv_start;
    assign conv_sel = s_r.conv;
    assign pop_data = s_r.pop_data;
    assign pop_valid = s_r.pop_valid;
    assign result_queue_status = s_r.qstat;
    assign queue_overflow_status = s_r.ovf;
    assign queue_underflow_status = s_r.unf;
    assign raw_irq_status = s_r.raw;
    assign gated_irq_status = s_r.gated;
    assign irq_line = s_r.gated;
    assign sequencer_priority = s_r.prio;
    assign averaging_control = s_r.avg;

    // checks; a frozen clock enable suspends them
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn || !ce);

    sequence arb_grant;
        s_r.st == ST_IDLE && s_r.tick && found;
    endsequence
    sequence step_finish;
        do_push && ctl[CTL_END];
    endsequence

    tick_period_a: assert property (s_r.tick |=> !s_r.tick [*7])
        else $error("adc tick spacing too short");
    depth_bound_a: assert property (s_r.cnt[0] <= 4'h8 && s_r.cnt[1] <= 4'h4
        && s_r.cnt[2] <= 4'h4 && s_r.cnt[3] <= 4'h1)
        else $error("queue count above depth");
    start_seq_a: assert property (arb_grant |=> s_r.st == ST_START ##[1:15] s_r.conv_start)
        else $error("granted sequencer never converts");
    end_step_a: assert property (step_finish |=> s_r.st == ST_IDLE)
        else $error("sequence did not end on last-sample step");
    irq_step_a: assert property (do_push && ctl[CTL_IE] |=> s_r.raw[$past(s_r.cur)])
        else $error("step interrupt not raised");
    ovf_set_a: assert property (do_push && s_r.qstat[s_r.cur].full
        |=> s_r.ovf[$past(s_r.cur)])
        else $error("overflow flag missed");
    unf_set_a: assert property (pop_req[0] && s_r.qstat[0].empty |=> s_r.unf[0])
        else $error("underflow flag missed");
    gated_sub_a: assert property ((s_r.gated & ~s_r.raw) == 4'h0)
        else $error("gated status without raw status");
    diff_pair_a: assert property (s_r.conv_start && s_r.conv.diff
        |-> s_r.conv.neg == s_r.conv.pos + 4'h1 && !s_r.conv.pos[0])
        else $error("differential pair mis-ordered");
endmodule : adcsq_top

// ===== adcsq_conv_model.sv
// behavioural converter model answering each conversion start of the sequencer
`timescale 1ns/1ps
module adcsq_conv_model
    import adcsq_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic conv_start,
    input wire adcsq_conv_t conv_sel,
    output logic conv_done,
    output logic [9:0] conv_code
);
    logic [9:0] code;
    // the code mirrors the selection, so the bench can see what was converted
    initial begin
        conv_done = 1'h0;
        conv_code = 10'h000;
        forever begin
            @(posedge mclk);
            #1;
            if (resetn && conv_start) begin
                code = {conv_sel.diff, conv_sel.temp, conv_sel.pos, conv_sel.neg};
                repeat (slow ? 20 : 2) @(posedge mclk);
                #1;
                conv_done = 1'h1;
                conv_code = code;
                @(posedge mclk);
                #1;
                conv_done = 1'h0;
                conv_code = ~code; // a stale code must not pass for a fresh one
            end
        end
    end
endmodule : adcsq_conv_model

// ===== adcsq_top_tb.sv
// self-checking bench for the four-sequencer converter control
`timescale 1ns/1ps
module adcsq_top_tb
    import adcsq_pkg::*;
;
    logic mclk, resetn, ce, prio_wr, avg_wr, conv_done, conv_start, pop_valid, slow;
    logic [3:0] run_bits, software_trigger_bit, irq_gate, irq_clear, ovf_clear;
    logic [3:0] unf_clear, pop_req, queue_overflow_status, queue_underflow_status;
    logic [3:0] raw_irq_status, gated_irq_status, irq_line;
    logic [3:0][3:0] trigger_select;
    logic [13:0] ext_trig;
    logic [7:0] prio_wdata, sequencer_priority;
    logic [2:0] avg_wdata, averaging_control;
    logic [3:0][7:0][3:0] step_input_select, step_control;
    logic [9:0] conv_code;
    logic [31:0] pop_data;
    adcsq_conv_t conv_sel;
    adcsq_qstat_t [3:0] result_queue_status;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int nconv = 0;
    int n0;
    // table rows: sequencer triggered and entries it should leave
    int row_seq[4] = '{0, 1, 2, 3};
    int row_n[4] = '{5, 4, 2, 1};
    int row_tail[4] = '{5, 0, 2, 0};

    adcsq_top dut (.mclk, .resetn, .ce, .run_bits, .trigger_select, .software_trigger_bit,
        .ext_trig, .prio_wr, .prio_wdata, .avg_wr, .avg_wdata, .step_input_select,
        .step_control, .irq_gate, .irq_clear, .ovf_clear, .unf_clear, .pop_req, .conv_done,
        .conv_code, .conv_start, .conv_sel, .pop_data, .pop_valid, .result_queue_status,
        .queue_overflow_status, .queue_underflow_status, .raw_irq_status, .gated_irq_status,
        .irq_line, .sequencer_priority, .averaging_control);
    adcsq_conv_model model (.mclk, .resetn, .slow, .conv_start, .conv_sel, .conv_done,
        .conv_code);

    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    // cycle and conversion counters; the ceiling cuts a hang short
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (conv_start === 1'h1) nconv <= nconv + 1;
        if (cyc == 12000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic clk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : clk

    task automatic check(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check

    // expected code from the selection rules, built apart from the model
    function automatic logic [9:0] exp_code(input logic [3:0] sel, input logic [3:0] ctl);
        if (ctl[CTL_DIFF]) return {1'h1, ctl[CTL_TEMP], sel[2:0], 1'h0, sel[2:0], 1'h1};
        return {1'h0, ctl[CTL_TEMP], sel, 4'h0};
    endfunction : exp_code

    task automatic pulse_trig(input logic [3:0] m);
        software_trigger_bit = m;
        clk(1);
        software_trigger_bit = 4'h0;
    endtask : pulse_trig

    // one read; the idle cycle after it keeps strobes from meeting in one step
    task automatic pop(input int s, input logic v, input logic [9:0] d);
        pop_req[s] = 1'h1;
        clk(1);
        pop_req = 4'h0;
        check(pop_valid === v && (!v || pop_data === {22'h0, d}), "pop result");
        clk(1);
    endtask : pop

    task automatic drain(input int s, input int n);
        for (int k = 0; k < n; k++)
            pop(s, 1'h1, exp_code(step_input_select[s][k], step_control[s][k]));
        pop(s, 1'h0, 10'h000);
        check(queue_underflow_status[s] === 1'h1 && result_queue_status[s].empty === 1'h1,
            "underflow flag");
        unf_clear[s] = 1'h1;
        clk(2);
        unf_clear = 4'h0;
        check(queue_underflow_status[s] === 1'h0, "underflow clear");
    endtask : drain

    task print_verdict();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    initial begin
        ce = 1'h1;
        resetn = 1'h0;
        run_bits = 4'hF;
        trigger_select = {4{TRIG_PROC}};
        {software_trigger_bit, irq_clear, ovf_clear, unf_clear, pop_req} = 20'h00000;
        {ext_trig, prio_wr, prio_wdata, avg_wr, avg_wdata, slow} = 28'h0000000;
        irq_gate = 4'h5;
        // step 0 of each sequence interrupts; inputs repeat within sequencer zero
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 8; k++) begin
                step_input_select[s][k] = 4'(4 * s + k % 4);
                step_control[s][k] = (k == 0) ? 4'h4 : 4'h0;
            end
        step_control[0][4][CTL_END] = 1'h1;
        step_control[1][3][CTL_END] = 1'h1;
        step_control[2][1] = 4'h3;
        step_control[1][2][CTL_TEMP] = 1'h1;
        step_control[3][0][CTL_END] = 1'h1;
        repeat (10) @(posedge mclk);
        #1 resetn = 1'h1;
        clk(1);
        check(sequencer_priority === 8'hE4 && averaging_control === 3'h0, "reset cfg");
        check(raw_irq_status === 4'h0 && result_queue_status[0].empty === 1'h1, "reset st");
        for (int r = 0; r < 4; r++) begin
            int s;
            s = row_seq[r];
            pulse_trig(4'(1 << s));
            clk(600);
            check(result_queue_status[s].head === 3'h0
                && result_queue_status[s].tail === 3'(row_tail[r]), "queue pointers");
            check(raw_irq_status[s] === 1'h1 && irq_line[s] === irq_gate[s]
                && gated_irq_status[s] === irq_gate[s], "irq");
            irq_clear[s] = 1'h1;
            clk(1);
            irq_clear = 4'h0;
            clk(2);
            check(raw_irq_status[s] === 1'h0 && irq_line[s] === 1'h0, "irq clear");
            drain(s, row_n[r]);
        end
        // distinct priorities with sequencer three on top
        prio_wdata = 8'h1B;
        prio_wr = 1'h1;
        clk(1);
        prio_wr = 1'h0;
        clk(1);
        check(sequencer_priority === 8'h1B, "priority write");
        pulse_trig(4'h9);
        for (int k = 0; k < 40 && conv_start !== 1'h1; k++) clk(1);
        check(conv_start === 1'h1 && conv_sel.pos === 4'hC, "priority order");
        clk(600);
        drain(3, 1);
        drain(0, 5);
        // second result into a one-entry queue is dropped
        pulse_trig(4'h8);
        clk(300);
        pulse_trig(4'h8);
        clk(300);
        check(queue_overflow_status === 4'h8 && result_queue_status[3].full === 1'h1,
            "overflow");
        ovf_clear = 4'h8;
        clk(2);
        ovf_clear = 4'h0;
        check(queue_overflow_status === 4'h0, "overflow clear");
        drain(3, 1);
        trigger_select[1] = 4'h1;
        ext_trig[0] = 1'h1;
        clk(8);
        ext_trig[0] = 1'h0;
        clk(600);
        drain(1, 4);
        run_bits = 4'h0;
        pulse_trig(4'hF);
        clk(100);
        check(result_queue_status[0].empty === 1'h1 && result_queue_status[2].empty === 1'h1,
            "stopped");
        run_bits = 4'hF;
        // averaging by two with a slow converter answer
        avg_wdata = 3'h7;
        avg_wr = 1'h1;
        clk(1);
        avg_wr = 1'h0;
        clk(1);
        check(averaging_control === 3'h6, "avg clamp");
        avg_wdata = 3'h1;
        avg_wr = 1'h1;
        clk(1);
        avg_wr = 1'h0;
        slow = 1'h1;
        n0 = nconv;
        pulse_trig(4'h8);
        clk(600);
        check(nconv - n0 === 2, "conversions per entry");
        drain(3, 1);
        resetn = 1'h0;
        clk(2);
        check(sequencer_priority === 8'hE4 && averaging_control === 3'h0
            && raw_irq_status === 4'h0, "second reset");
        resetn = 1'h1;
        clk(50);
        print_verdict();
    end
endmodule : adcsq_top_tb
